// ---- swr_regs.svh ----
// Timing constants for the single-wire bus master front end.
// Assumes a 100 MHz core clock; every count is derived from a time in ns.
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

// ==========================================================================
// Clock
`define SWR_CLK_PERIOD_NS        10

// ==========================================================================
// Standard speed times in ns
`define SWR_STD_RESET_LOW_NS     480000
`define SWR_STD_RESET_HIGH_NS    480000
`define SWR_STD_PRES_SAMPLE_NS   70000
`define SWR_STD_SLOT_NS          65000
`define SWR_STD_W0_LOW_NS        60000
`define SWR_STD_W1_LOW_NS        6000
`define SWR_STD_RD_LOW_NS        6000
`define SWR_STD_RD_SAMPLE_NS     14000
`define SWR_STD_RECOVERY_NS      5000

// ==========================================================================
// Overdrive times in ns
`define SWR_OD_RESET_LOW_NS      56000
`define SWR_OD_RESET_HIGH_NS     48000
`define SWR_OD_PRES_SAMPLE_NS    8000
`define SWR_OD_SLOT_NS           10000
`define SWR_OD_W0_LOW_NS         8000
`define SWR_OD_W1_LOW_NS         1000
`define SWR_OD_RD_LOW_NS         1000
`define SWR_OD_RD_SAMPLE_NS      2000
`define SWR_OD_RECOVERY_NS       2000

// ==========================================================================
// ROM function command codes
`define SWR_CMD_SKIP             8'hCC
`define SWR_CMD_RESUME           8'hA5
`define SWR_CMD_OD_SKIP          8'h3C
`define SWR_CMD_OD_MATCH         8'h69
`define SWR_CMD_MATCH            8'h55

// ==========================================================================
// Derived cycle counts (least times round up)
`define SWR_CYC(ns) (((ns) + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)

`endif

// ---- swr_pkg.sv ----
// Types shared by the single-wire bus master front end.
// Assumes nothing beyond a SystemVerilog compiler.
package swr_pkg;

	// ==========================================================================
	// Requests accepted on the user port
	typedef enum logic [2:0] {
		REQ_RESET,
		REQ_WRITE_BIT,
		REQ_READ_BIT,
		REQ_SKIP,
		REQ_RESUME,
		REQ_OD_SKIP,
		REQ_MATCH,
		REQ_OD_MATCH
	} swr_req_type;

endpackage

// ---- swr_master.sv ----
// Single-wire bus master: reset and presence, bit slots, ROM-layer selection.
// Assumes the line input is synchronous to core_clk and an external pull-up.
`timescale 1ns/1ps
`include "swr_regs.svh"

module swr_master #(
	parameter int unsigned STD_RESET_LOW_CYC  = `SWR_CYC(`SWR_STD_RESET_LOW_NS),
	parameter int unsigned STD_RESET_HIGH_CYC = `SWR_CYC(`SWR_STD_RESET_HIGH_NS),
	parameter int unsigned FALL_EXTRA_CYC     = 1
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	// User request
	input  wire logic               reqValid,
	output logic                    reqReady,
	input  wire swr_pkg::swr_req_type reqKind,
	input  wire logic               reqBit,
	input  wire logic [63:0]        reqRomId,
	// User answer
	output logic                    doneValid,
	output logic                    doneBit,
	output logic                    presenceSeen,
	output logic                    fastSpeed,
	// Bus line
	input  wire logic               lineIn,
	output logic                    lineOut,
	output logic                    lineOe_b
);

	// ==========================================================================
	// Timing selection
	localparam int unsigned CW = 17;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RST_LOW,
		ST_RST_HIGH,
		ST_SLOT,
		ST_RECOVER
	} swr_state_type;

	function automatic logic [CW-1:0] pick(input logic fast, input int unsigned s,
		input int unsigned f);
		pick = fast ? CW'(f) : CW'(s);
	endfunction

	swr_state_type state;
	swr_state_type next_state;
	logic [CW-1:0] timer;
	logic [CW-1:0] next_timer;
	logic [71:0]   shiftData;
	logic [71:0]   next_shiftData;
	logic [6:0]    bitsLeft;
	logic [6:0]    next_bitsLeft;
	logic          curBit;
	logic          next_curBit;
	logic          isRead;
	logic          next_isRead;
	logic          fastAfter;
	logic          next_fastAfter;
	logic          next_fastSpeed;
	logic          next_doneValid;
	logic          next_doneBit;
	logic          next_presenceSeen;
	logic          sampled;
	logic          next_sampled;
	logic          next_lineLow;
	logic          lineLow;

	logic [CW-1:0] tRstLow;
	logic [CW-1:0] tRstHigh;
	logic [CW-1:0] tPresSample;
	logic [CW-1:0] tSlot;
	logic [CW-1:0] tW0Low;
	logic [CW-1:0] tW1Low;
	logic [CW-1:0] tRdLow;
	logic [CW-1:0] tRdSample;
	logic [CW-1:0] tRecovery;

	always_comb begin
		// Fast timing applies to every waveform but the long reset low once overdrive is on.
		// A reset asked for as long always uses the standard length.
		tRstLow     = pick(fastSpeed & ~curBit, STD_RESET_LOW_CYC + FALL_EXTRA_CYC,
			`SWR_CYC(`SWR_OD_RESET_LOW_NS) + FALL_EXTRA_CYC);
		tRstHigh    = pick(fastSpeed, STD_RESET_HIGH_CYC,
			`SWR_CYC(`SWR_OD_RESET_HIGH_NS));
		tPresSample = pick(fastSpeed, `SWR_CYC(`SWR_STD_PRES_SAMPLE_NS),
			`SWR_CYC(`SWR_OD_PRES_SAMPLE_NS));
		tSlot       = pick(fastSpeed, `SWR_CYC(`SWR_STD_SLOT_NS), `SWR_CYC(`SWR_OD_SLOT_NS));
		tW0Low      = pick(fastSpeed, `SWR_CYC(`SWR_STD_W0_LOW_NS), `SWR_CYC(`SWR_OD_W0_LOW_NS));
		tW1Low      = pick(fastSpeed, `SWR_CYC(`SWR_STD_W1_LOW_NS), `SWR_CYC(`SWR_OD_W1_LOW_NS));
		tRdLow      = pick(fastSpeed, `SWR_CYC(`SWR_STD_RD_LOW_NS), `SWR_CYC(`SWR_OD_RD_LOW_NS));
		tRdSample   = pick(fastSpeed, `SWR_CYC(`SWR_STD_RD_SAMPLE_NS),
			`SWR_CYC(`SWR_OD_RD_SAMPLE_NS));
		tRecovery   = pick(fastSpeed, `SWR_CYC(`SWR_STD_RECOVERY_NS),
			`SWR_CYC(`SWR_OD_RECOVERY_NS));
	end

	// ==========================================================================
	// Sequencer
	assign reqReady = (state == ST_IDLE);
	assign lineOut  = 1'b0;
	assign lineOe_b = ~lineLow;

	always_comb begin
		next_state        = state;
		next_timer        = timer + CW'(1);
		next_shiftData    = shiftData;
		next_bitsLeft     = bitsLeft;
		next_curBit       = curBit;
		next_isRead       = isRead;
		next_fastAfter    = fastAfter;
		next_fastSpeed    = fastSpeed;
		next_doneValid    = 1'b0;
		next_doneBit      = doneBit;
		next_presenceSeen = presenceSeen;
		next_sampled      = sampled;
		next_lineLow      = 1'b0;
		case (state)
			ST_IDLE: begin
				next_timer = '0;
				if (reqValid) begin
					next_isRead    = 1'b0;
					next_fastAfter = fastSpeed;
					case (reqKind)
						swr_pkg::REQ_RESET: begin
							// A reset of the full long length drops overdrive.
							// Bit high asks for the long reset; low keeps the present speed.
							next_state   = ST_RST_LOW;
							next_lineLow = 1'b1;
							next_curBit  = reqBit;
						end
						swr_pkg::REQ_WRITE_BIT: begin
							next_shiftData = {71'h0, reqBit};
							next_bitsLeft  = 7'h01;
						end
						swr_pkg::REQ_READ_BIT: begin
							next_isRead   = 1'b1;
							next_bitsLeft = 7'h01;
						end
						swr_pkg::REQ_SKIP: begin
							next_shiftData = {64'h0, `SWR_CMD_SKIP};
							next_bitsLeft  = 7'h08;
						end
						swr_pkg::REQ_RESUME: begin
							next_shiftData = {64'h0, `SWR_CMD_RESUME};
							next_bitsLeft  = 7'h08;
						end
						swr_pkg::REQ_OD_SKIP: begin
							next_shiftData = {64'h0, `SWR_CMD_OD_SKIP};
							next_bitsLeft  = 7'h08;
							next_fastAfter = 1'b1;
						end
						swr_pkg::REQ_MATCH: begin
							// Selecting one slave also disarms the resume flag of others.
							next_shiftData = {reqRomId, `SWR_CMD_MATCH};
							next_bitsLeft  = 7'h48;
						end
						default: begin
							// The identifier follows the code at fast timing.
							next_shiftData = {reqRomId, `SWR_CMD_OD_MATCH};
							next_bitsLeft  = 7'h48;
							next_fastAfter = 1'b1;
						end
					endcase
					if (reqKind != swr_pkg::REQ_RESET) begin
						next_state   = ST_SLOT;
						next_lineLow = 1'b1;
						next_curBit  = (reqKind == swr_pkg::REQ_WRITE_BIT) ? reqBit :
							(reqKind == swr_pkg::REQ_READ_BIT) ? 1'b1 : next_shiftData[0];
					end
				end
			end
			ST_RST_LOW: begin
				next_lineLow = 1'b1;
				if (timer >= tRstLow - CW'(1)) begin
					// A long reset drops overdrive here; presence is cleared for a fresh sample.
					next_state     = ST_RST_HIGH;
					next_timer     = '0;
					next_lineLow      = 1'b0;
					next_fastSpeed    = fastSpeed & ~curBit;
					next_sampled      = 1'b0;
					next_presenceSeen = 1'b0;
				end
			end
			ST_RST_HIGH: begin
				// The slave answers with presence after release.
				if (timer == tPresSample) begin
					next_presenceSeen = ~lineIn;
					next_sampled      = 1'b1;
				end
				if (timer >= tRstHigh - CW'(1)) begin
					next_state     = ST_IDLE;
					next_doneValid = 1'b1;
					next_doneBit   = next_sampled & next_presenceSeen;
				end
			end
			ST_SLOT: begin
				// One bit per slot; a one or read releases early.
				if (curBit) begin
					next_lineLow = (timer < (isRead ? tRdLow : tW1Low) - CW'(1));
				end else begin
					next_lineLow = (timer < tW0Low - CW'(1));
				end
				if (isRead && timer == tRdSample) begin
					next_doneBit = lineIn;
				end
				if (timer >= tSlot - CW'(1)) begin
					next_state   = ST_RECOVER;
					next_timer   = '0;
					next_lineLow = 1'b0;
				end
			end
			ST_RECOVER: begin
				// Line stays released for the recovery gap.
				if (timer >= tRecovery - CW'(1)) begin
					next_timer     = '0;
					next_shiftData = {1'b0, shiftData[71:1]};
					next_bitsLeft  = bitsLeft - 7'h01;
					if (bitsLeft == 7'h01) begin
						next_state     = ST_IDLE;
						next_doneValid = 1'b1;
						next_fastSpeed = fastAfter;
					end else begin
						// Identifier bits after an overdrive match go at fast timing.
						if (bitsLeft == 7'h41 && fastAfter) begin
							next_fastSpeed = 1'b1;
						end
						next_state   = ST_SLOT;
						next_lineLow = 1'b1;
						next_curBit  = shiftData[1];
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state        <= ST_IDLE;
			timer        <= '0;
			shiftData    <= '0;
			bitsLeft     <= '0;
			curBit       <= 1'b0;
			isRead       <= 1'b0;
			fastAfter    <= 1'b0;
			fastSpeed    <= 1'b0;
			doneValid    <= 1'b0;
			doneBit      <= 1'b0;
			presenceSeen <= 1'b0;
			sampled      <= 1'b0;
			lineLow      <= 1'b0;
		end else begin
			state        <= next_state;
			timer        <= next_timer;
			shiftData    <= next_shiftData;
			bitsLeft     <= next_bitsLeft;
			curBit       <= next_curBit;
			isRead       <= next_isRead;
			fastAfter    <= next_fastAfter;
			fastSpeed    <= next_fastSpeed;
			doneValid    <= next_doneValid;
			doneBit      <= next_doneBit;
			presenceSeen <= next_presenceSeen;
			sampled      <= next_sampled;
			lineLow      <= next_lineLow;
		end
	end

endmodule

// ---- swr_master_chk.sv ----
// Port checker for the single-wire bus master.
// Assumes it is bound onto swr_master and sees only its ports.
`timescale 1ns/1ps
`include "swr_regs.svh"

module swr_master_chk #(
	parameter int unsigned STD_RESET_LOW_CYC  = 200,
	parameter int unsigned STD_RESET_HIGH_CYC = 200,
	parameter int unsigned FALL_EXTRA_CYC     = 1
) (
	// Clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst_b,
	// User side
	input wire logic                 reqValid,
	input wire logic                 reqReady,
	input wire swr_pkg::swr_req_type reqKind,
	input wire logic                 reqBit,
	input wire logic                 doneValid,
	input wire logic                 doneBit,
	input wire logic                 presenceSeen,
	input wire logic                 fastSpeed,
	// Bus
	input wire logic                 lineOe_b
);
	localparam int unsigned W0S = `SWR_CYC(`SWR_STD_W0_LOW_NS);
	localparam int unsigned W0F = `SWR_CYC(`SWR_OD_W0_LOW_NS);
	localparam int unsigned W1S = `SWR_CYC(`SWR_STD_W1_LOW_NS);
	localparam int unsigned W1F = `SWR_CYC(`SWR_OD_W1_LOW_NS);
	localparam int unsigned RLF = `SWR_CYC(`SWR_OD_RESET_LOW_NS);

	swr_pkg::swr_req_type kind;
	logic                 bitV;
	logic                 fastV;
	int unsigned          lowCnt;

	// ========
	// Latches what was taken, so low times can be judged per request.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			kind   <= swr_pkg::REQ_RESET;
			bitV   <= 1'b0;
			fastV  <= 1'b0;
			lowCnt <= '0;
		end else begin
			if (reqValid && reqReady) begin
				kind  <= reqKind;
				bitV  <= reqBit;
				fastV <= fastSpeed;
			end
			lowCnt <= lineOe_b ? '0 : lowCnt + 1;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_take_busy: assert property (reqValid && reqReady |=> !reqReady)
		else $error("busy not shown after take");
	a_done_pulse: assert property (doneValid |=> !doneValid)
		else $error("done longer than one cycle");
	a_idle_free: assert property (reqReady |-> lineOe_b)
		else $error("line driven while idle");
	a_slot_low: assert property (reqValid && reqReady |-> ##[1:2] !lineOe_b)
		else $error("request did not pull line low");
	a_w0_low: assert property ($rose(lineOe_b) && kind == swr_pkg::REQ_WRITE_BIT && !bitV
		|-> lowCnt == (fastV ? W0F : W0S)) else $error("write zero low time wrong");
	a_w1_low: assert property ($rose(lineOe_b) && kind == swr_pkg::REQ_WRITE_BIT && bitV
		|-> lowCnt == (fastV ? W1F : W1S)) else $error("write one low time wrong");
	a_rst_low: assert property ($rose(lineOe_b) && kind == swr_pkg::REQ_RESET
		|-> lowCnt == ((fastV && !bitV) ? RLF : STD_RESET_LOW_CYC) + FALL_EXTRA_CYC)
		else $error("reset low time wrong");
	a_rst_std: assert property (doneValid && kind == swr_pkg::REQ_RESET
		|-> fastSpeed == (fastV && !bitV)) else $error("speed wrong after reset");
	a_skip_fast: assert property (doneValid && kind == swr_pkg::REQ_OD_SKIP
		|-> ##[0:1] fastSpeed) else $error("fast speed not set");
	a_fast_drop: assert property ($fell(fastSpeed) |-> kind == swr_pkg::REQ_RESET && bitV)
		else $error("fast speed lost without reset");
	a_pres_bit: assert property (doneValid && kind == swr_pkg::REQ_RESET
		|-> doneBit == presenceSeen) else $error("presence result differs");
endmodule

bind swr_master swr_master_chk #(
	.STD_RESET_LOW_CYC (STD_RESET_LOW_CYC),
	.STD_RESET_HIGH_CYC(STD_RESET_HIGH_CYC),
	.FALL_EXTRA_CYC    (FALL_EXTRA_CYC)
) u_swr_master_chk (
	.core_clk    (core_clk),
	.rst_b       (rst_b),
	.reqValid    (reqValid),
	.reqReady    (reqReady),
	.reqKind     (reqKind),
	.reqBit      (reqBit),
	.doneValid   (doneValid),
	.doneBit     (doneBit),
	.presenceSeen(presenceSeen),
	.fastSpeed   (fastSpeed),
	.lineOe_b    (lineOe_b)
);

// ---- swr_slave_model.sv ----
// Behavioural slave at the far end of the single-wire line.
// Assumes a 10 ns clock and the shortened standard reset of the bench.
`timescale 1ns/1ps

module swr_slave_model #(
	parameter int LONG_RST  = 6500,
	parameter int SHORT_RST = 4000
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// Line
	input  wire logic lineIn,
	output logic      pullLow,
	// Observation
	output logic      rxBit,
	output int        rxCount
);
	int         lowCnt;
	int         presT;
	int         hold;
	int         bitCnt;
	logic       fast;
	logic       sel;
	logic [7:0] cmd;
	logic       bitIn;

	// ========
	// Only presence starts here; a selected slave answers each slot with 0.
	assign pullLow = hold != 0 || (presT > (fast ? 200 : 3000) && presT <= (fast ? 1000 : 7500));
	assign bitIn = lowCnt < (fast ? 300 : 3000);
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{lowCnt, presT, hold, bitCnt, rxCount} <= '0;
			{fast, sel, rxBit, cmd} <= '0;
		end else if (presT != 0) begin
			presT <= presT > (fast ? 1200 : 7800) ? 0 : presT + 1;
		end else if (!lineIn) begin
			if (lowCnt == 0 && sel) hold <= fast ? 250 : 2000;
			else if (hold != 0) hold <= hold - 1;
			lowCnt <= lowCnt + 1;
		end else if (lowCnt != 0) begin
			lowCnt <= 0;
			if (lowCnt >= (fast ? SHORT_RST : LONG_RST)) begin
				fast   <= fast && lowCnt < LONG_RST;
				sel    <= 1'b0;
				bitCnt <= 0;
				presT  <= 1;
			end else if (!sel && bitCnt < 8) begin
				rxBit   <= bitIn;
				rxCount <= rxCount + 1;
				cmd     <= {bitIn, cmd[7:1]};
				bitCnt  <= bitCnt + 1;
				if (bitCnt == 7)
					case ({bitIn, cmd[7:1]})
						8'hCC: sel <= 1'b1;
						8'h3C: {sel, fast} <= 2'b11;
						// No identifier match is modelled, so resume is never armed.
						default: sel <= 1'b0;
					endcase
			end
		end
	end
endmodule

// ---- tb_swr_master.sv ----
// Self-checking bench for the single-wire master against a slave model.
// Assumes the design, checker and slave model are compiled before it.
`timescale 1ns/1ps

module tb_swr_master;
	logic                 core_clk;
	logic                 rst_b;
	logic                 reqValid;
	logic                 reqReady;
	swr_pkg::swr_req_type reqKind;
	logic                 reqBit;
	logic [63:0]          reqRomId;
	logic                 doneValid;
	logic                 doneBit;
	logic                 presenceSeen;
	logic                 fastSpeed;
	logic                 lineOut;
	logic                 lineOe_b;
	logic                 pullLow;
	logic                 rxBit;
	logic                 line;
	logic                 b;
	int                   rxCount;
	int                   miscompares;
	int                   comparisons;
	int                   cycles;
	int                   expRx;

	// Open drain: the pull-up wins unless a side drives low.
	assign line = (lineOe_b | lineOut) & !pullLow;

	swr_master #(
		.STD_RESET_LOW_CYC (32'h1B58),
		.STD_RESET_HIGH_CYC(32'h1F40),
		.FALL_EXTRA_CYC    (32'h1)
	) u_swr_master (
		.core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady),
		.reqKind(reqKind), .reqBit(reqBit), .reqRomId(reqRomId), .doneValid(doneValid),
		.doneBit(doneBit), .presenceSeen(presenceSeen), .fastSpeed(fastSpeed),
		.lineIn(line), .lineOut(lineOut), .lineOe_b(lineOe_b)
	);
	swr_slave_model u_swr_slave_model (
		.core_clk(core_clk), .rst_b(rst_b), .lineIn(line), .pullLow(pullLow),
		.rxBit(rxBit), .rxCount(rxCount)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ========
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 32'h19A28) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Holds the request until taken, then waits for the one-cycle done.
	task automatic run(input swr_pkg::swr_req_type k, input logic v);
		int n;
		n = 0;
		reqKind  <= k;
		reqBit   <= v;
		reqValid <= 1'b1;
		@(negedge core_clk);
		while (!reqReady) @(negedge core_clk);
		@(posedge core_clk);
		reqValid <= 1'b0;
		while (doneValid !== 1'b1 && n < 32'h15F90) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 32'h15F90) miscompares++;
		@(posedge core_clk);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{rst_b, reqValid, reqBit, cycles, miscompares, comparisons} = '0;
		reqKind  = swr_pkg::REQ_RESET;
		reqRomId = '0;
		void'($urandom(32'hBA96));
		repeat (4) @(posedge core_clk);
		check("idle line", 1, lineOe_b);
		rst_b    <= 1'b1;
		reqRomId <= {$urandom, $urandom};
		@(posedge core_clk);
		run(swr_pkg::REQ_RESET, 1'b0);
		check("presence", 1, presenceSeen);
		check("speed", 0, fastSpeed);
		$display("test standard reset ended");
		run(swr_pkg::REQ_OD_SKIP, 1'b0);
		check("speed", 1, fastSpeed);
		check("slave bits", 8, rxCount);
		run(swr_pkg::REQ_READ_BIT, 1'b1);
		check("selected read", 0, doneBit);
		$display("test overdrive skip ended");
		run(swr_pkg::REQ_RESET, 1'b0);
		check("fast presence", 1, presenceSeen);
		check("speed", 1, fastSpeed);
		$display("test fast reset ended");
		expRx = 8;
		b = 1'($urandom);
		repeat (2) begin
			run(swr_pkg::REQ_WRITE_BIT, b);
			expRx++;
			check("slave bit", b, rxBit);
			check("slave count", expRx, rxCount);
			b = !b;
		end
		$display("test write bits ended");
		run(swr_pkg::REQ_RESET, 1'b1);
		check("standard presence", 1, doneBit);
		check("speed", 0, fastSpeed);
		$display("test long reset ended");
		print_verdict();
	end
endmodule
